// >>> hw/bai_exec.v
/*
 * decode and execute of the absolute branch and the increment-file
 * instructions, in four phases per instruction cycle.
 * timing, counted in clock edges from the decode (q1) edge:
 *   edge 0 decodes the word and sets the file read address,
 *   edge 1 captures the literal and the file read data,
 *   edge 2 forms the incremented value,
 *   edge 3 writes the program counter, accumulator or file register,
 *   edges 4..7 after a branch are the flushed cycle.
 * only the two opcodes act; every other word leaves the program counter, accumulator, zero flag and file registers alone.
 * assumes instr_word is stable for a whole cycle from the fetch unit,
 * and file_rdata answers file_raddr combinationally, same clock.
 */
`timescale 1ns/1ps
`include "bai_defs.vh"

module bai_exec (
    input wire sys_clk,
    input wire rst_n,
    input wire [13:0] instr_word,
    input wire [7:0] program_counter_high_latch,
    input wire [7:0] file_rdata,
    output reg [12:0] program_counter_q,
    output reg [7:0] w_reg_q,
    output reg zero_flag_q,
    output reg [6:0] file_raddr_q,
    output reg [6:0] file_waddr_q,
    output reg [7:0] file_wdata_q,
    output reg file_we_q,
    output reg flush_q,
    output reg [1:0] phase_out_q
);
    localparam ST_EXEC = 1'h0;
    localparam ST_FLUSH = 1'h1;

    wire [1:0] phase;
    wire cycle_end;
    wire dec_branch;
    wire dec_increment_file;
    wire [12:0] branch_target;
    wire [7:0] inc_sum;
    wire inc_zero;

    // decode and datapath state
    reg state_q;
    reg state_d;
    reg is_branch_q;
    reg is_branch_d;
    reg is_increment_file_q;
    reg is_increment_file_d;
    reg dest_q;
    reg dest_d;
    reg [10:0] lit_q;
    reg [10:0] lit_d;
    reg [7:0] operand_q;
    reg [7:0] operand_d;
    reg [7:0] result_q;
    reg [7:0] result_d;

    // next values of the output registers
    reg [12:0] program_counter_d;
    reg [7:0] w_reg_d;
    reg zero_flag_d;
    reg [6:0] file_raddr_d;
    reg [6:0] file_waddr_d;
    reg [7:0] file_wdata_d;
    reg file_we_d;
    reg flush_d;
    reg [1:0] phase_out_d;

    bai_phase_gen u_phase (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .phase_q(phase),
        .cycle_end_q(cycle_end)
    );

    // flush cycle holds the already fetched word off the datapath
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (cycle_end && is_branch_q) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (cycle_end) begin
                    state_d = ST_EXEC;
                end
            end
            default: state_d = ST_EXEC;
        endcase
    end

    // opcode match ignores the operand bits
    assign dec_branch = ((instr_word & `BAI_OPC_BRANCH_MASK) == `BAI_OPC_BRANCH);
    assign dec_increment_file = ((instr_word & `BAI_OPC_INCREMENT_FILE_MASK) == `BAI_OPC_INCREMENT_FILE);
    assign branch_target = {program_counter_high_latch[`BAI_LATCH_HI:`BAI_LATCH_LO],
        lit_q};
    assign inc_sum = operand_q + 8'h01;
    assign inc_zero = (result_q == 8'h00);

    // decode and datapath pipeline, one step in each of phases one to three; phase four holds them
    always @* begin
        is_branch_d = is_branch_q;
        is_increment_file_d = is_increment_file_q;
        dest_d = dest_q;
        lit_d = lit_q;
        operand_d = operand_q;
        result_d = result_q;
        case (phase)
            `BAI_PHASE_Q1: begin
                if (state_q == ST_EXEC) begin
                    is_branch_d = dec_branch;
                    is_increment_file_d = dec_increment_file;
                    dest_d = instr_word[`BAI_DEST_BIT];
                end else begin
                    // the word fetched behind a branch is dropped here
                    is_branch_d = 1'h0;
                    is_increment_file_d = 1'h0;
                end
            end
            `BAI_PHASE_Q2: begin
                lit_d = instr_word[`BAI_LIT_MSB:0];
                operand_d = file_rdata;
            end
            `BAI_PHASE_Q3: begin
                result_d = inc_sum;
            end
            default: begin
                result_d = result_q;
            end
        endcase
    end

    // output registers; apart from phase_out_q, which follows every phase, only phase one and phase four move them
    always @* begin
        program_counter_d = program_counter_q;
        w_reg_d = w_reg_q;
        zero_flag_d = zero_flag_q;
        file_raddr_d = file_raddr_q;
        file_waddr_d = file_waddr_q;
        file_wdata_d = file_wdata_q;
        file_we_d = 1'h0;
        flush_d = (state_d == ST_FLUSH);
        phase_out_d = phase;
        case (phase)
            `BAI_PHASE_Q1: begin
                if (state_q == ST_EXEC) begin
                    file_raddr_d = instr_word[`BAI_FADDR_MSB:0];
                end
            end
            `BAI_PHASE_Q4: begin
                if (is_branch_q) begin
                    program_counter_d = branch_target;
                end else if (is_increment_file_q) begin
                    zero_flag_d = inc_zero;
                    if (dest_q) begin
                        file_waddr_d = file_raddr_q;
                        file_wdata_d = result_q;
                        file_we_d = 1'h1;
                    end else begin
                        w_reg_d = result_q;
                    end
                end
            end
            default: begin
                file_we_d = 1'h0;
            end
        endcase
    end

    // internal pipeline registers
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_EXEC;
            is_branch_q <= `BAI_FLAG_RESET;
            is_increment_file_q <= `BAI_FLAG_RESET;
            dest_q <= `BAI_FLAG_RESET;
            lit_q <= `BAI_LIT_RESET;
            operand_q <= `BAI_DATA_RESET;
            result_q <= `BAI_DATA_RESET;
        end else begin
            state_q <= state_d;
            is_branch_q <= is_branch_d;
            is_increment_file_q <= is_increment_file_d;
            dest_q <= dest_d;
            lit_q <= lit_d;
            operand_q <= operand_d;
            result_q <= result_d;
        end
    end

    // synchronous reset parks every output at zero
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            program_counter_q <= `BAI_PC_RESET;
            w_reg_q <= `BAI_W_RESET;
            zero_flag_q <= `BAI_FLAG_RESET;
            file_raddr_q <= `BAI_FADDR_RESET;
            file_waddr_q <= `BAI_FADDR_RESET;
            file_wdata_q <= `BAI_DATA_RESET;
            file_we_q <= `BAI_FLAG_RESET;
            flush_q <= `BAI_FLAG_RESET;
            phase_out_q <= `BAI_PHASE_Q1;
        end else begin
            program_counter_q <= program_counter_d;
            w_reg_q <= w_reg_d;
            zero_flag_q <= zero_flag_d;
            file_raddr_q <= file_raddr_d;
            file_waddr_q <= file_waddr_d;
            file_wdata_q <= file_wdata_d;
            file_we_q <= file_we_d;
            flush_q <= flush_d;
            phase_out_q <= phase_out_d;
        end
    end
endmodule

// >>> hw/bai_defs.vh
/*
 * constants for the branch/increment execute block: opcode fields,
 * phase encodings and reset values.
 * assumes inclusion by bare name from the design files only.
 */
`ifndef BAI_DEFS_VH
`define BAI_DEFS_VH

`define BAI_OPC_BRANCH_MASK 14'h3800
`define BAI_OPC_BRANCH 14'h2800
`define BAI_OPC_INCREMENT_FILE_MASK 14'h3f00
`define BAI_OPC_INCREMENT_FILE 14'h0a00
`define BAI_LIT_MSB 10
`define BAI_DEST_BIT 7
`define BAI_FADDR_MSB 6
`define BAI_LATCH_HI 4
`define BAI_LATCH_LO 3
`define BAI_PHASE_Q1 2'h0
`define BAI_PHASE_Q2 2'h1
`define BAI_PHASE_Q3 2'h2
`define BAI_PHASE_Q4 2'h3
`define BAI_PC_RESET 13'h0000
`define BAI_W_RESET 8'h00
`define BAI_LIT_RESET 11'h000
`define BAI_FADDR_RESET 7'h00
`define BAI_DATA_RESET 8'h00
`define BAI_FLAG_RESET 1'h0

`endif

// >>> hw/bai_phase_gen.v
/*
 * four-phase sequencer: q1..q4 per instruction cycle, one clock each.
 * assumes a free-running core clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "bai_defs.vh"

module bai_phase_gen (
    input wire sys_clk,
    input wire rst_n,
    output reg [1:0] phase_q,
    output reg cycle_end_q
);
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= `BAI_PHASE_Q1;
            cycle_end_q <= `BAI_FLAG_RESET;
        end else begin
            phase_q <= phase_q + 2'h1;
            // high during q4 so the top can close the cycle
            cycle_end_q <= (phase_q == `BAI_PHASE_Q3);
        end
    end
endmodule

// >>> dv/bai_exec_props.sv
/* assertions on the bai_exec ports.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module bai_exec_props (
    input wire sys_clk,
    input wire rst_n,
    input wire [13:0] instr_word,
    input wire [7:0] program_counter_high_latch,
    input wire [7:0] file_rdata,
    input wire [12:0] program_counter_q,
    input wire [7:0] w_reg_q,
    input wire zero_flag_q,
    input wire [6:0] file_raddr_q,
    input wire [6:0] file_waddr_q,
    input wire [7:0] file_wdata_q,
    input wire file_we_q,
    input wire flush_q,
    input wire [1:0] phase_out_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence flush_run;
        flush_q [*4] ##1 !flush_q;
    endsequence
    chk_we_pulse: assert property (file_we_q |=> !file_we_q) else $error("long strobe");
    chk_we_addr: assert property (file_we_q |-> file_waddr_q == file_raddr_q)
        else $error("waddr");
    chk_wdata_inc: assert property (file_we_q |-> file_wdata_q == $past(file_rdata, 3) + 8'h01)
        else $error("wdata");
    chk_zero_flag: assert property (file_we_q |-> zero_flag_q == (file_wdata_q == 8'h00))
        else $error("zero");
    chk_w_incr: assert property ($changed(w_reg_q) |-> w_reg_q == $past(file_rdata, 3) + 8'h01
        && !file_we_q) else $error("w");
    chk_pc_branch: assert property ($changed(program_counter_q) |-> $rose(flush_q))
        else $error("pc");
    chk_flush_len: assert property ($rose(flush_q) |-> flush_run) else $error("flush");
    chk_branch_tgt: assert property ($rose(flush_q) |-> program_counter_q ==
        {$past(program_counter_high_latch[4:3]), $past(instr_word[10:0])}) else $error("target");
    chk_flush_quiet: assert property ($fell(flush_q) |->
        !file_we_q && $stable(w_reg_q)) else $error("flushed cycle wrote");
    chk_phase_step: assert property ($past(rst_n, 2) |->
        phase_out_q == $past(phase_out_q) + 2'h1) else $error("phase order");
endmodule

// >>> dv/tb_top.sv
/* self-checking bench for bai_exec against a small model.
   assumes the file memory is modelled here. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0, rst_n = 0, z = 0;
    logic [13:0] iw = 0;
    logic [7:0] lat = 0, w = 0, r, mem [128];
    logic [12:0] pc = 0;
    logic [10:0] k;
    logic [6:0] f;
    int n_mismatch = 0, checks_done = 0;
    wire [12:0] pc_q;
    wire [7:0] w_q, wd_q;
    wire [6:0] ra_q, wa_q;
    wire z_q, we_q, fl_q;
    wire [1:0] ph_q;
    bai_exec uut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_word(iw),
        .program_counter_high_latch(lat), .file_rdata(mem[ra_q]), .program_counter_q(pc_q),
        .w_reg_q(w_q), .zero_flag_q(z_q), .file_raddr_q(ra_q), .file_waddr_q(wa_q),
        .file_wdata_q(wd_q), .file_we_q(we_q), .flush_q(fl_q), .phase_out_q(ph_q));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one instruction cycle: word held for four clocks
    task automatic run(logic [13:0] wd, logic we, logic fl);
        iw = wd;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp("pc", pc, pc_q);
        cmp("w", w, w_q);
        cmp("zero", z, z_q);
        cmp("we", we, we_q);
        cmp("flush", fl, fl_q);
        cmp("phase", 2'h3, ph_q);
        if (we) cmp("wdata", {wd[6:0], r}, {wa_q, wd_q});
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #10000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h530f002b));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1;
        for (int i = 0; i < 40; i++) begin
            f = (i == 1) ? 7'h7f : 7'($urandom);
            k = 11'($urandom);
            if (i % 5 == 0) mem[f] = 8'hff;
            r = mem[f] + 8'h01;
            lat = 8'($urandom);
            if (i % 4 < 2) begin
                z = r === 8'h00;
                if (!i[0]) w = r;
                run({6'h0a, i[0], f}, i[0], 0);
                if (i[0]) mem[f] = r;
            end else if (i % 4 == 2) begin
                pc = {lat[4:3], k};
                run({3'h5, k}, 1'h0, 1'h1);
                run({6'h0a, 1'h1, f}, 1'h0, 1'h0);
            end else run({6'h30, k[7:0]}, 0, 0);
            $display("test %0d done", i);
        end
        complete_run;
    end
endmodule
bind bai_exec bai_exec_props chk (.sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
    .program_counter_high_latch(program_counter_high_latch), .file_rdata(file_rdata),
    .program_counter_q(program_counter_q), .w_reg_q(w_reg_q), .zero_flag_q(zero_flag_q),
    .file_raddr_q(file_raddr_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q),
    .file_we_q(file_we_q), .flush_q(flush_q), .phase_out_q(phase_out_q));
